// *** src/sysctl_regs.sv ***
// System control register bank with vector remap and peripheral resets.
`timescale 1ns/1ns
`default_nettype none
`include "sysctl_cfg.svh"

// How it works
// R1: Each register sits on its own aligned 32-bit word.
// R2: The bank decodes at base 0x4004_8000, register chosen by byte offset.
// R3: Remap field 0 sends vector fetches to boot ROM.
// R4: Remap field 1 sends vector fetches to on-chip SRAM.
// R5: Remap field 2 leaves vectors in flash; field resets to binary 10.
// R6: Writing 0 to a peripheral reset bit asserts that peripheral's reset.
// R7: Writing 1 releases the peripheral reset until 0 is written again.
// R8: Software writes 1 to reset bits before using the peripherals.
// R9: Peripheral reset register resets to zero, holding peripherals reset.
// R10: Bus clock gate register at 0x080 is read/write, resets to 0x85F.
// R11: Core bus divider at 0x078 is read/write, resets to 0x001.
// R12: Wake-latch clear at 0x208 is write-only; writes clear wake latches.
// R13: Wake-latch status at 0x20C is read-only; writes do nothing.
// R14: Deep-sleep power config at 0x230 is read/write, resets to zero.
// R15: Wake power config at 0x234 is read/write, low half resets to EDF0.
// R16: Pin capture at 0x100 is read-only, holds pins sampled after reset.
// R17: Reset bits: 0 serial port 0, 1 two-wire, 2 serial port 1, 3 CAN.
// R18: Software accesses whole registers only, never single bytes.
// R19: Reserved offsets and bits read zero; writes to them are ignored.
// R20: Write-only registers read zero; read-only ones ignore writes.
module sysctl_regs #(
  parameter logic [31:0] PART_ID = 32'h0000_1234  // Arbitrary value.
) (
  input  wire logic        sys_clk_i,
  input  wire logic        rst_i,
  input  wire logic        sel_i,
  input  wire logic        wr_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [31:0] wdata_i,
  output logic      [31:0] rdata_o,
  output logic             hit_o,
  input  wire logic        pll_lock_i,
  input  wire logic [31:0] reset_cause_i,
  input  wire logic [31:0] pin_cap0_i,
  input  wire logic [31:0] pin_cap1_i,
  input  wire logic [12:0] wake_latch_i,
  output logic      [12:0] wake_latch_clr_o,
  output sysctl_pkg::sysctl_vec_t vec_map_o,
  output logic             vec_boot_o,
  output logic             vec_sram_o,
  output logic             serial0_rst_n_o,
  output logic             twowire_rst_n_o,
  output logic             serial1_rst_n_o,
  output logic             can_rst_n_o,
  output logic      [31:0] bus_clk_gate_o,
  output logic      [31:0] core_bus_div_o
);

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  // Each read/write register except the run power config is an index into a small array.
  localparam int NRW = 27;
  localparam logic [11:0] RW_OFS [NRW] = '{
    `OFS_VECTOR_REMAP, `OFS_PERIPH_RESET, `OFS_PLL_CTRL, `OFS_XTAL_OSC,
    `OFS_LP_OSC, `OFS_RC_TRIM, `OFS_PLL_SRC_SEL, `OFS_PLL_SRC_UPD,
    `OFS_MAIN_SRC_SEL, `OFS_MAIN_SRC_UPD, `OFS_CORE_BUS_DIV,
    `OFS_BUS_CLK_GATE, `OFS_SER0_DIV, `OFS_ASER_DIV, `OFS_SER1_DIV,
    `OFS_WD_SRC_SEL, `OFS_WD_SRC_UPD, `OFS_WD_DIV, `OFS_CKO_SRC_SEL,
    `OFS_CKO_SRC_UPD, `OFS_CKO_DIV, `OFS_BROWNOUT, `OFS_TICK_CAL,
    `OFS_WAKE_EDGE, `OFS_WAKE_ENABLE, `OFS_SLEEP_PWR, `OFS_WAKE_PWR};
  localparam logic [31:0] RW_RST [NRW] = '{
    `RST_VECTOR_REMAP, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
    `RST_RC_TRIM, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
    `RST_CORE_BUS_DIV, `RST_BUS_CLK_GATE, `RST_ZERO, `RST_ZERO, `RST_ZERO,
    `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO, `RST_ZERO,
    `RST_ZERO, `RST_TICK_CAL, `RST_ZERO, `RST_ZERO, `RST_ZERO,
    `RST_WAKE_PWR};
  // Implemented bits; reserved bits are never stored, so they read zero.
  localparam logic [31:0] RW_MSK [NRW] = '{
    `REMAP_MASK, `PRST_MASK, `PLL_CTRL_MASK, `XTAL_OSC_MASK,
    `LP_OSC_MASK, `RC_TRIM_MASK, `SEL_MASK, `UPD_MASK, `SEL_MASK,
    `UPD_MASK, `DIV_MASK, `ALL_ONES, `DIV_MASK, `DIV_MASK, `DIV_MASK,
    `SEL_MASK, `UPD_MASK, `DIV_MASK, `SEL_MASK, `UPD_MASK, `DIV_MASK,
    `BROWNOUT_MASK, `TICK_CAL_MASK, `WAKE_MASK, `WAKE_MASK, `PWR_MASK,
    `PWR_MASK};
  localparam int IX_REMAP = 0;
  localparam int IX_PRST  = 1;
  localparam int IX_DIV   = 10;
  localparam int IX_GATE  = 11;

  logic [11:0] ofs;
  logic        in_bank;
  logic        wr_en;
  logic [31:0] rw_ff [NRW];
  logic [31:0] run_pwr_ff;

  // Low two address bits are ignored: every register is a whole word.
  function automatic logic ofs_is(input logic [11:0] a,
                                  input logic [11:0] o);
    ofs_is = (a[11:2] == o[11:2]);  // R1
  endfunction : ofs_is

  assign ofs     = addr_i[11:0];
  assign in_bank = ((addr_i & `SYSCTL_SPAN_MASK) == `SYSCTL_BASE);  // R2
  assign wr_en   = sel_i && wr_i && in_bank;
  assign hit_o   = sel_i && in_bank;

  // ------------------------------------------------------------------
  // Read/write storage
  // ------------------------------------------------------------------
  // Reset values 0 for the peripheral resets hold them asserted.
  genvar gi;
  generate
    for (gi = 0; gi < NRW; gi++) begin : g_rw
      always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
          rw_ff[gi] <= RW_RST[gi];  // R5 R9 R10 R11 R14 R15
        end else if (wr_en && ofs_is(ofs, RW_OFS[gi])) begin
          rw_ff[gi] <= wdata_i & RW_MSK[gi];  // R6 R7 R19
        end
      end
    end
  endgenerate

  // Run power config sits after the array so its own reset is kept clear.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      run_pwr_ff <= `RST_RUN_PWR;
    end else if (wr_en && ofs_is(ofs, `OFS_RUN_PWR)) begin
      run_pwr_ff <= wdata_i & `PWR_MASK;
    end
  end

  // ------------------------------------------------------------------
  // Wake latch clear strobe and pin capture
  // ------------------------------------------------------------------
  // The clear strobe lasts one cycle per write; it is not stored.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      wake_latch_clr_o <= 13'h0;
    end else if (wr_en && ofs_is(ofs, `OFS_WAKE_CLEAR)) begin
      wake_latch_clr_o <= wdata_i[12:0];  // R12
    end else begin
      wake_latch_clr_o <= 13'h0;
    end
  end

  // Pins are caught on the first edge after reset release, then frozen.
  logic        cap_done_ff;
  logic [31:0] cap0_ff;
  logic [31:0] cap1_ff;
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cap_done_ff <= 1'b0;
    end else begin
      cap_done_ff <= 1'b1;
    end
  end
  always_ff @(posedge sys_clk_i) begin
    if (!cap_done_ff && !rst_i) begin
      cap0_ff <= pin_cap0_i;  // R16
      cap1_ff <= pin_cap1_i;
    end
  end

  // ------------------------------------------------------------------
  // Read mux
  // ------------------------------------------------------------------
  logic [31:0] nxt_rdata;
  always_comb begin
    nxt_rdata = 32'h0;  // R19 R20
    for (int i = 0; i < NRW; i++) begin
      if (ofs_is(ofs, RW_OFS[i])) begin
        nxt_rdata = rw_ff[i];
      end
    end
    if (ofs_is(ofs, `OFS_RUN_PWR)) begin
      nxt_rdata = run_pwr_ff;
    end
    if (ofs_is(ofs, `OFS_PLL_LOCK)) begin
      nxt_rdata = {31'h0, pll_lock_i};
    end
    if (ofs_is(ofs, `OFS_RESET_CAUSE)) begin
      nxt_rdata = reset_cause_i;
    end
    if (ofs_is(ofs, `OFS_PIN_CAP0)) begin
      nxt_rdata = cap0_ff;  // R16
    end
    if (ofs_is(ofs, `OFS_PIN_CAP1)) begin
      nxt_rdata = cap1_ff;
    end
    if (ofs_is(ofs, `OFS_WAKE_STATUS)) begin
      nxt_rdata = {19'h0, wake_latch_i};  // R13
    end
    if (ofs_is(ofs, `OFS_PART_ID)) begin
      nxt_rdata = PART_ID;
    end
    if (!in_bank) begin
      nxt_rdata = 32'h0;
    end
  end

  // Read data is registered: valid on the cycle after sel_i with wr_i low.
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rdata_o <= 32'h0;
    end else if (sel_i && !wr_i) begin
      rdata_o <= nxt_rdata;
    end
  end

  // ------------------------------------------------------------------
  // Vector remap, peripheral reset, clock gate and divider outputs
  // ------------------------------------------------------------------
  always_comb begin
    vec_map_o = sysctl_pkg::sysctl_vec_t'(rw_ff[IX_REMAP][`REMAP_MSB:0]);
    vec_boot_o = (vec_map_o == sysctl_pkg::SYSCTL_VEC_BOOT);  // R3
    vec_sram_o = (vec_map_o == sysctl_pkg::SYSCTL_VEC_SRAM);  // R4
  end
  // Code 3 is left unmapped, so like flash mode it redirects nothing.

  // Active-low resets follow the stored bits directly.
  assign serial0_rst_n_o = rw_ff[IX_PRST][0];  // R17 R6 R7
  assign twowire_rst_n_o = rw_ff[IX_PRST][1];  // R17
  assign serial1_rst_n_o = rw_ff[IX_PRST][2];  // R17
  assign can_rst_n_o     = rw_ff[IX_PRST][3];  // R17
  assign bus_clk_gate_o  = rw_ff[IX_GATE];  // R10
  assign core_bus_div_o  = rw_ff[IX_DIV];  // R11

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_prst_wr(logic [3:0] v);
    wr_en && ofs_is(ofs, `OFS_PERIPH_RESET) && wdata_i[3:0] == v;
  endsequence

  chk_remap_reset: assert property (@(posedge sys_clk_i)  // R5
    rst_i |=> vec_map_o == sysctl_pkg::SYSCTL_VEC_FLASH && !vec_boot_o)
    else $error("remap field did not reset to flash mode");
  chk_boot_select: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_en && ofs_is(ofs, `OFS_VECTOR_REMAP) && wdata_i[1:0] == 2'h0  // R3
    |=> vec_boot_o && !vec_sram_o)
    else $error("boot ROM not selected after writing 0");
  chk_sram_select: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_en && ofs_is(ofs, `OFS_VECTOR_REMAP) && wdata_i[1:0] == 2'h1  // R4
    |=> vec_sram_o && !vec_boot_o)
    else $error("SRAM not selected after writing 1");
  chk_periph_assert: assert property (@(posedge sys_clk_i)  // R6
    disable iff (rst_i)
    s_prst_wr(4'h0) |=> !serial0_rst_n_o && !twowire_rst_n_o)
    else $error("peripheral reset not asserted by writing 0");
  chk_periph_release: assert property (@(posedge sys_clk_i)  // R7
    disable iff (rst_i)
    s_prst_wr(4'hF) ##1 !(wr_en && ofs_is(ofs, `OFS_PERIPH_RESET))
    |=> serial0_rst_n_o && serial1_rst_n_o && can_rst_n_o)
    else $error("peripheral reset not held released");
  chk_prst_reset: assert property (@(posedge sys_clk_i)  // R9
    rst_i |=> !serial0_rst_n_o && !twowire_rst_n_o && !can_rst_n_o)
    else $error("peripheral resets not asserted after reset");
  chk_gate_div_reset: assert property (@(posedge sys_clk_i)  // R10
    rst_i |=> bus_clk_gate_o == `RST_BUS_CLK_GATE
              && core_bus_div_o == `RST_CORE_BUS_DIV)
    else $error("clock gate or divider reset value wrong");
  chk_clear_pulse: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    wr_en && ofs_is(ofs, `OFS_WAKE_CLEAR)  // R12
    |=> wake_latch_clr_o == $past(wdata_i[12:0]))
    else $error("wake latch clear strobe wrong");
  chk_wo_reads_zero: assert property (@(posedge sys_clk_i)  // R20
    disable iff (rst_i)
    sel_i && !wr_i && ofs_is(ofs, `OFS_WAKE_CLEAR) |=> rdata_o == 32'h0)
    else $error("write-only register read nonzero");
  chk_cap_frozen: assert property (@(posedge sys_clk_i) disable iff (rst_i)
    cap_done_ff && $past(cap_done_ff) |-> $stable(cap0_ff))  // R16
    else $error("pin capture changed after reset");

  // ------------------------------------------------------------------
  // Read-back and output checks
  // ------------------------------------------------------------------
  // The clock gate and divider are traced from their write to their read-back
  // and to their output, the sleep and wake power configs to read-back only.
  sequence s_wr(logic [11:0] o);
    wr_en && ofs_is(ofs, o);
  endsequence
  sequence s_rd(logic [11:0] o);
    sel_i && !wr_i && in_bank && ofs_is(ofs, o);
  endsequence
  sequence s_wr_rd(logic [11:0] o);
    s_wr(o) ##1 s_rd(o);
  endsequence

  chk_clear_ends: assert property (@(posedge sys_clk_i)  // R12
    disable iff (rst_i)
    s_wr(`OFS_WAKE_CLEAR) ##1 !(wr_en && ofs_is(ofs, `OFS_WAKE_CLEAR))
    |=> wake_latch_clr_o == 13'h0)
    else $error("wake latch clear strobe did not end");
  chk_status_read: assert property (@(posedge sys_clk_i)  // R13
    disable iff (rst_i)
    s_rd(`OFS_WAKE_STATUS) |=> rdata_o == {19'h0, $past(wake_latch_i)})
    else $error("wake latch status read wrong");
  chk_part_id_read: assert property (@(posedge sys_clk_i)  // R20
    disable iff (rst_i)
    s_rd(`OFS_PART_ID) |=> rdata_o == PART_ID)
    else $error("part identifier read wrong");
  chk_outside_zero: assert property (@(posedge sys_clk_i)  // R2
    disable iff (rst_i)
    sel_i && !wr_i && !in_bank |=> rdata_o == 32'h0)
    else $error("read outside the bank returned data");
  chk_word_decode: assert property (@(posedge sys_clk_i)  // R1
    disable iff (rst_i)
    s_rd(`OFS_CORE_BUS_DIV) |=> rdata_o == $past(core_bus_div_o))
    else $error("divider read back wrong");

  chk_sleep_rw: assert property (@(posedge sys_clk_i)  // R14
    disable iff (rst_i)
    s_wr_rd(`OFS_SLEEP_PWR) |=> rdata_o == ($past(wdata_i, 2) & `PWR_MASK))
    else $error("deep-sleep config read back wrong");
  chk_wake_pwr_rw: assert property (@(posedge sys_clk_i)  // R15
    disable iff (rst_i)
    s_wr_rd(`OFS_WAKE_PWR) |=> rdata_o == ($past(wdata_i, 2) & `PWR_MASK))
    else $error("wake power config read back wrong");
  chk_gate_rw: assert property (@(posedge sys_clk_i)  // R10
    disable iff (rst_i)
    s_wr_rd(`OFS_BUS_CLK_GATE) |=> rdata_o == $past(wdata_i, 2))
    else $error("clock gate read back wrong");
  chk_div_rw: assert property (@(posedge sys_clk_i)  // R11
    disable iff (rst_i)
    s_wr_rd(`OFS_CORE_BUS_DIV)
    |=> rdata_o == ($past(wdata_i, 2) & `DIV_MASK))
    else $error("divider write not read back");

  chk_gate_out: assert property (@(posedge sys_clk_i)  // R10
    disable iff (rst_i)
    s_wr(`OFS_BUS_CLK_GATE) |=> bus_clk_gate_o == $past(wdata_i))
    else $error("clock gate output not updated by write");
  chk_div_out: assert property (@(posedge sys_clk_i)  // R11
    disable iff (rst_i)
    s_wr(`OFS_CORE_BUS_DIV)
    |=> core_bus_div_o == ($past(wdata_i) & `DIV_MASK))
    else $error("divider output not updated by write");
  chk_periph_bits: assert property (@(posedge sys_clk_i)  // R17
    disable iff (rst_i)
    s_wr(`OFS_PERIPH_RESET) |=> {can_rst_n_o, serial1_rst_n_o,
      twowire_rst_n_o, serial0_rst_n_o} == $past(wdata_i[`PRST_W-1:0]))
    else $error("peripheral reset bits in wrong positions");
  chk_cap_first_edge: assert property (@(posedge sys_clk_i)  // R16
    rst_i ##1 !rst_i |=> cap0_ff == $past(pin_cap0_i))
    else $error("pin capture missed the first edge after reset");

endmodule : sysctl_regs
`default_nettype wire

// *** src/sysctl_cfg.svh ***
// Register offsets, reset values and field positions of the system control bank.
`ifndef SYSCTL_CFG_SVH
`define SYSCTL_CFG_SVH

`define SYSCTL_BASE          32'h4004_8000
`define SYSCTL_SPAN_MASK     32'hFFFF_C000
`define SYSCTL_OFS_MASK      32'h0000_0FFF
`define SYSCTL_OFS_W         12

`define OFS_VECTOR_REMAP     12'h000
`define OFS_PERIPH_RESET     12'h004
`define OFS_PLL_CTRL         12'h008
`define OFS_PLL_LOCK         12'h00C
`define OFS_XTAL_OSC         12'h020
`define OFS_LP_OSC           12'h024
`define OFS_RC_TRIM          12'h028
`define OFS_RESET_CAUSE      12'h030
`define OFS_PLL_SRC_SEL      12'h040
`define OFS_PLL_SRC_UPD      12'h044
`define OFS_MAIN_SRC_SEL     12'h070
`define OFS_MAIN_SRC_UPD     12'h074
`define OFS_CORE_BUS_DIV     12'h078
`define OFS_BUS_CLK_GATE     12'h080
`define OFS_SER0_DIV         12'h094
`define OFS_ASER_DIV         12'h098
`define OFS_SER1_DIV         12'h09C
`define OFS_WD_SRC_SEL       12'h0D0
`define OFS_WD_SRC_UPD       12'h0D4
`define OFS_WD_DIV           12'h0D8
`define OFS_CKO_SRC_SEL      12'h0E0
`define OFS_CKO_SRC_UPD      12'h0E4
`define OFS_CKO_DIV          12'h0E8
`define OFS_PIN_CAP0         12'h100
`define OFS_PIN_CAP1         12'h104
`define OFS_BROWNOUT         12'h150
`define OFS_TICK_CAL         12'h154
`define OFS_WAKE_EDGE        12'h200
`define OFS_WAKE_ENABLE      12'h204
`define OFS_WAKE_CLEAR       12'h208
`define OFS_WAKE_STATUS      12'h20C
`define OFS_SLEEP_PWR        12'h230
`define OFS_WAKE_PWR         12'h234
`define OFS_RUN_PWR          12'h238
`define OFS_PART_ID          12'h3F4

`define RST_ZERO             32'h0000_0000
`define RST_VECTOR_REMAP     32'h0000_0002
`define RST_RC_TRIM          32'h0000_0080
`define RST_CORE_BUS_DIV     32'h0000_0001
`define RST_BUS_CLK_GATE     32'h0000_085F
`define RST_TICK_CAL         32'h0000_0004
`define RST_WAKE_PWR         32'h0000_EDF0
`define RST_RUN_PWR          32'h0000_EDF0

`define REMAP_MSB            1
`define PRST_W               4
`define ALL_ONES             32'hFFFF_FFFF
`define REMAP_MASK           32'h0000_0003
`define PRST_MASK            32'h0000_000F
`define PLL_CTRL_MASK        32'h0000_007F
`define XTAL_OSC_MASK        32'h0000_0003
`define LP_OSC_MASK          32'h0000_01FF
`define RC_TRIM_MASK         32'h0000_00FF
`define SEL_MASK             32'h0000_0003
`define UPD_MASK             32'h0000_0001
`define DIV_MASK             32'h0000_00FF
`define BROWNOUT_MASK        32'h0000_001F
`define TICK_CAL_MASK        32'h03FF_FFFF
`define WAKE_MASK            32'h0000_1FFF
`define PWR_MASK             32'h0000_FFFF

`endif

// *** src/sysctl_pkg.sv ***
// Types shared by the system control register bank.
`default_nettype none
package sysctl_pkg;
  typedef enum logic [1:0] {
    SYSCTL_VEC_BOOT  = 2'h0,
    SYSCTL_VEC_SRAM  = 2'h1,
    SYSCTL_VEC_FLASH = 2'h2,
    SYSCTL_VEC_RSVD  = 2'h3
  } sysctl_vec_t;
endpackage : sysctl_pkg
`default_nettype wire

// *** tb/tb_sysctl_regs.sv ***
// Self-checking bench for the system control register bank.
`timescale 1ns/1ns
`default_nettype none
module tb_sysctl_regs;
  // --------------------------------------------------------------------
  // Signals and design instance
  // --------------------------------------------------------------------
  localparam logic [31:0] ID   = 32'h0000_ABCD;  // Arbitrary value.
  localparam logic [31:0] BASE = 32'h4004_8000;
  localparam logic [31:0] CAP0 = 32'hA5A5_5A5A;
  localparam logic [31:0] CAP1 = 32'h0F0F_1234;
  logic                    sys_clk_i;
  logic                    rst_i;
  logic                    sel_i;
  logic                    wr_i;
  logic                    pll_lock_i;
  logic [31:0]             addr_i;
  logic [31:0]             wdata_i;
  logic [31:0]             reset_cause_i;
  logic [31:0]             pin_cap0_i;
  logic [31:0]             pin_cap1_i;
  logic [12:0]             wake_latch_i;
  logic [31:0]             rdata_o;
  logic                    hit_o;
  logic [12:0]             wake_latch_clr_o;
  sysctl_pkg::sysctl_vec_t vec_map_o;
  logic                    vec_boot_o;
  logic                    vec_sram_o;
  logic                    serial0_rst_n_o;
  logic                    twowire_rst_n_o;
  logic                    serial1_rst_n_o;
  logic                    can_rst_n_o;
  logic [31:0]             bus_clk_gate_o;
  logic [31:0]             core_bus_div_o;
  logic                    last_hit;
  logic [3:0]              pats [4];
  int                      n_mismatch;
  int                      checks;

  sysctl_regs #(.PART_ID(ID)) u_sysctl_regs (
    .sys_clk_i(sys_clk_i), .rst_i(rst_i), .sel_i(sel_i), .wr_i(wr_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .hit_o(hit_o),
    .pll_lock_i(pll_lock_i), .reset_cause_i(reset_cause_i),
    .pin_cap0_i(pin_cap0_i), .pin_cap1_i(pin_cap1_i),
    .wake_latch_i(wake_latch_i), .wake_latch_clr_o(wake_latch_clr_o),
    .vec_map_o(vec_map_o), .vec_boot_o(vec_boot_o), .vec_sram_o(vec_sram_o),
    .serial0_rst_n_o(serial0_rst_n_o), .twowire_rst_n_o(twowire_rst_n_o),
    .serial1_rst_n_o(serial1_rst_n_o), .can_rst_n_o(can_rst_n_o),
    .bus_clk_gate_o(bus_clk_gate_o), .core_bus_div_o(core_bus_div_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  // --------------------------------------------------------------------
  // Access and compare tasks
  // --------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got,
               exp);
    end
  endtask : chk

  // Called at a falling edge; the request is taken at the next rising edge.
  // The request stays up on return, so back-to-back calls never drop and
  // raise sel_i in one time step; idle() releases it for a cycle.
  task automatic acc(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    sel_i   = 1'b1;
    wr_i    = w;
    addr_i  = a;
    wdata_i = d;
    #1 last_hit = hit_o;
    @(negedge sys_clk_i);
  endtask : acc

  task automatic idle();
    sel_i = 1'b0;
    wr_i  = 1'b0;
    @(negedge sys_clk_i);
  endtask : idle

  task automatic wr(input logic [11:0] ofs, input logic [31:0] d);
    acc(1'b1, BASE + {20'h0, ofs}, d);
  endtask : wr

  task automatic rc(input logic [11:0] ofs, input logic [31:0] exp,
                    input string what);
    acc(1'b0, BASE + {20'h0, ofs}, 32'h0);
    chk(rdata_o, exp, what);
  endtask : rc

  function automatic logic [31:0] rsts();
    return {28'h0, can_rst_n_o, serial1_rst_n_o, twowire_rst_n_o,
            serial0_rst_n_o};
  endfunction : rsts

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : report_and_stop

  initial begin
    #(40 * 1000);
    n_mismatch++;
    report_and_stop();
  end

  // --------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------
  initial begin
    n_mismatch = 0;
    checks = 0;
    rst_i = 1'b1;
    sel_i = 1'b0;
    wr_i = 1'b0;
    addr_i = 32'h0;
    wdata_i = 32'h0;
    pll_lock_i = 1'b1;
    reset_cause_i = 32'h0000_0013;
    pin_cap0_i = CAP0;
    pin_cap1_i = CAP1;
    wake_latch_i = 13'h0A5C;
    pats = '{4'hF, 4'h5, 4'hA, 4'h0};
    repeat (3) @(negedge sys_clk_i);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    // The capture edge has passed, so later pin changes must not show.
    pin_cap0_i = ~CAP0;
    pin_cap1_i = 32'h0;
    chk({30'h0, vec_map_o}, 32'h2, "map reset");
    chk(rsts(), 32'h0, "periph reset outs");
    rc(12'h000, 32'h0000_0002, "remap reset");
    rc(12'h004, 32'h0, "periph reset reg");
    rc(12'h080, 32'h0000_085F, "gate reset");
    rc(12'h078, 32'h0000_0001, "div reset");
    rc(12'h230, 32'h0, "sleep cfg reset");
    rc(12'h234, 32'h0000_EDF0, "wake cfg reset");
    rc(12'h028, 32'h0000_0080, "trim reset");
    rc(12'h3F4, ID, "part id");
    chk(bus_clk_gate_o, 32'h0000_085F, "gate out");
    chk(core_bus_div_o, 32'h0000_0001, "div out");
    $display("test reset values done");

    for (int c = 0; c < 4; c++) begin
      wr(12'h000, 32'hFFFF_FFFC | 32'(c));
      chk({30'h0, vec_map_o}, 32'(c), "map out");
      chk({31'h0, vec_boot_o}, {31'h0, c == 0}, "boot sel");
      chk({31'h0, vec_sram_o}, {31'h0, c == 1}, "sram sel");
      rc(12'h000, 32'(c), "remap readback");
    end
    wr(12'h000, 32'h0000_0002);
    $display("test vector remap done");

    foreach (pats[i]) begin
      wr(12'h004, {28'hFFF_FFFF, pats[i]});
      chk(rsts(), {28'h0, pats[i]}, "periph reset outs");
      rc(12'h004, {28'h0, pats[i]}, "periph reset reg");
    end
    wr(12'h004, 32'h0000_000F);
    chk(rsts(), 32'h0000_000F, "periph resets released");
    $display("test peripheral resets done");

    wr(12'h080, 32'h1234_5678);
    chk(bus_clk_gate_o, 32'h1234_5678, "gate out");
    rc(12'h080, 32'h1234_5678, "gate rb");
    wr(12'h078, 32'hFFFF_FF3C);
    chk(core_bus_div_o, 32'h0000_003C, "div out");
    rc(12'h078, 32'h0000_003C, "div rb");
    wr(12'h230, 32'hFFFF_FFFF);
    rc(12'h230, 32'h0000_FFFF, "sleep cfg rb");
    wr(12'h234, 32'h1234_5678);
    rc(12'h234, 32'h0000_5678, "wake cfg rb");
    $display("test read write registers done");

    wr(12'h208, 32'hFFFF_1ABC);
    chk({19'h0, wake_latch_clr_o}, 32'h0000_1ABC, "clear pulse");
    idle();
    chk({19'h0, wake_latch_clr_o}, 32'h0, "clear pulse end");
    rc(12'h208, 32'h0, "write-only read");
    wr(12'h20C, 32'hFFFF_FFFF);
    rc(12'h20C, 32'h0000_0A5C, "latch status");
    wr(12'h00C, 32'h0);
    rc(12'h00C, 32'h1, "lock status");
    rc(12'h030, 32'h0000_0013, "reset cause");
    wr(12'h100, 32'h0);
    rc(12'h100, CAP0, "pin capture 0");
    rc(12'h104, CAP1, "pin capture 1");
    $display("test read-only and write-only done");

    wr(12'h010, 32'hFFFF_FFFF);
    rc(12'h010, 32'h0, "reserved offset");
    chk({31'h0, last_hit}, 32'h1, "in-bank hit");
    acc(1'b1, 32'h4004_C080, 32'h0);
    chk({31'h0, last_hit}, 32'h0, "out-of-bank hit");
    acc(1'b0, 32'h4004_C080, 32'h0);
    chk(rdata_o, 32'h0, "out-of-bank read");
    acc(1'b0, BASE + 32'h0000_007A, 32'h0);
    chk(rdata_o, 32'h0000_003C, "word aligned decode");
    rc(12'h080, 32'h1234_5678, "gate untouched");
    $display("test address decode done");

    wr(12'h000, 32'h0000_0001);
    idle();
    rst_i = 1'b1;
    repeat (2) @(negedge sys_clk_i);
    rst_i = 1'b0;
    @(negedge sys_clk_i);
    chk({30'h0, vec_map_o}, 32'h2, "map after mid reset");
    chk(rsts(), 32'h0, "periph outs after mid reset");
    chk(bus_clk_gate_o, 32'h0000_085F, "gate after mid reset");
    chk(core_bus_div_o, 32'h0000_0001, "div after mid reset");
    rc(12'h230, 32'h0, "sleep cfg after mid reset");
    $display("test mid-run reset done");
    report_and_stop();
  end
endmodule : tb_sysctl_regs
`default_nettype wire
